/* addr_timing_pkg.sv */
// Purpose: shared constants for stack-relative address and timing logic
// Assumes: 16-bit program counter and stack pointer, 24-bit addresses
// Notes: mode codes are local choices

package addr_timing_pkg;

  localparam int ADDR_W = 24;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;

  localparam logic [7:0] ZERO_BANK  = 8'h00;
  localparam logic [7:0] PAGE_ALIGN = 8'h00;

  // addressing modes
  typedef enum logic [4:0] {
    MODE_ABS          = 5'h00,
    MODE_ABS_IDX_IND  = 5'h01,
    MODE_ABS_IND      = 5'h02,
    MODE_ABS_LONG     = 5'h03,
    MODE_ABS_LONG_X   = 5'h04,
    MODE_ABS_X        = 5'h05,
    MODE_ABS_Y        = 5'h06,
    MODE_ACC          = 5'h07,
    MODE_BLOCK_MOVE   = 5'h08,
    MODE_DIR          = 5'h09,
    MODE_DIR_IDX_IND  = 5'h0a,
    MODE_DIR_IND      = 5'h0b,
    MODE_DIR_IND_IDX  = 5'h0c,
    MODE_DIR_IND_LIDX = 5'h0d,
    MODE_DIR_IND_LONG = 5'h0e,
    MODE_DIR_X        = 5'h0f,
    MODE_DIR_Y        = 5'h10,
    MODE_IMM          = 5'h11,
    MODE_IMPLIED      = 5'h12,
    MODE_REL          = 5'h13,
    MODE_REL_LONG     = 5'h14,
    MODE_STACK        = 5'h15,
    MODE_STACK_REL    = 5'h16,
    MODE_STACK_REL_IY = 5'h17
  } addr_mode_t;

  // base cycle counts
  localparam logic [3:0] CYC_ABS          = 4'h4;
  localparam logic [3:0] CYC_ABS_IDX_IND  = 4'h6;
  localparam logic [3:0] CYC_ABS_IND      = 4'h5;
  localparam logic [3:0] CYC_ABS_LONG     = 4'h5;
  localparam logic [3:0] CYC_TWO          = 4'h2;
  localparam logic [3:0] CYC_BLOCK_MOVE   = 4'h7;
  localparam logic [3:0] CYC_DIR          = 4'h3;
  localparam logic [3:0] CYC_DIR_X        = 4'h4;
  localparam logic [3:0] CYC_DIR_IND      = 4'h5;
  localparam logic [3:0] CYC_DIR_SIX      = 4'h6;
  localparam logic [3:0] CYC_REL          = 4'h2;
  localparam logic [3:0] CYC_REL_LONG     = 4'h3;
  localparam logic [3:0] CYC_STACK        = 4'h3;
  localparam logic [3:0] CYC_STACK_REL    = 4'h4;
  localparam logic [3:0] CYC_STACK_REL_IY = 4'h7;

  // adjustments
  localparam logic [3:0] ADD_ONE        = 4'h1;
  localparam logic [3:0] ADD_RMW_NARROW = 4'h2;
  localparam logic [3:0] ADD_RMW_WIDE   = 4'h3;

  // instruction lengths in bytes
  localparam logic [2:0] LEN_ONE   = 3'h1;
  localparam logic [2:0] LEN_TWO   = 3'h2;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_FOUR  = 3'h4;

endpackage

/* stack_rel_addr_timing.sv */
// Purpose: relative branch, stack and stack-relative address generation
//          plus per-instruction cycle and length accounting
// Assumes: sequencer presents operands on i_start; all inputs synchronous
// Notes: results registered; o_valid pulses one cycle after i_start, or one cycle after i_pointer_valid for indirect indexed

`timescale 1ns/1ps

// What this block does
// - taken branch adds operand to pc already at next opcode
// - short displacement is signed byte, -128 to +127
// - branch changes only 16-bit pc; program bank never altered
// - push, pull, call, return, interrupt accesses use bank zero
// - interrupt vector fetches always use bank zero
// - stack-relative low 16 bits are stack pointer plus offset byte
// - stack-relative upper address byte forced to zero
// - stack-relative offset zero-extended, range 0 to 255
// - indirect indexed pointer read from bank zero at stack plus offset
// - data bank value supplies upper base byte for indirect indexed
// - indirect indexed address is 24-bit base plus second index
// - absolute family base cycles: 6, 5, 4, 5
// - direct-page base cycles: 3, 4, 5, 6
// - stack-relative 4 cycles, indirect indexed 7, two bytes each
// - branches 2 or 3 cycles, plus one when taken
// - one extra cycle when absolute X/Y or direct indirect indexed crosses a 256-byte page (not stack-relative indirect indexed)
// - 16-bit width adds a cycle; immediate gains one byte
// - direct modes add a cycle when direct base low byte nonzero
// - read-modify-write adds two cycles if width flag set, else three
// - immediate operand is byte two, or bytes two and three when wide
module stack_rel_addr_timing (
  // clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  input  wire logic                      i_enable,
  // request from sequencer
  input  wire logic                      i_start,
  input  wire addr_timing_pkg::addr_mode_t i_mode,
  input  wire logic                      i_branch_taken,
  input  wire logic                      i_rmw,
  input  wire logic                      i_vector_fetch,
  input  wire logic                      i_imm_uses_index,
  input  wire logic                      i_page_cross,
  // operand bytes and core state
  input  wire logic [7:0]                i_operand_low,
  input  wire logic [7:0]                i_operand_high,
  input  wire logic [15:0]               i_program_counter,
  input  wire logic [7:0]                i_program_bank_value,
  input  wire logic [7:0]                i_data_bank_value,
  input  wire logic [15:0]               i_stack_pointer,
  input  wire logic [15:0]               i_direct_base,
  input  wire logic [15:0]               i_index_y,
  input  wire logic                      i_acc_width_flag,
  input  wire logic                      i_index_width_flag,
  // indirect pointer fetched from bank zero
  input  wire logic                      i_pointer_valid,
  input  wire logic [15:0]               i_pointer_data,
  // results
  output logic                           o_valid,
  output logic [23:0]                    o_address,
  output logic [15:0]                    o_next_pc,
  output logic [7:0]                     o_next_program_bank,
  output logic                           o_pointer_req,
  output logic [23:0]                    o_pointer_address,
  output logic [3:0]                     o_cycles,
  output logic [2:0]                     o_length,
  output logic                           o_page_crossed
);

  // sign-extend a short displacement
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction

  // zero-extend and wrap inside bank zero
  function automatic logic [15:0] stack_sum(input logic [15:0] sp, input logic [7:0] off);
    stack_sum = sp + {8'h00, off};
  endfunction

  // page crossing test for an index add
  function automatic logic crosses(input logic [15:0] base, input logic [15:0] idx);
    logic [16:0] s;
    s = {1'b0, base} + {1'b0, idx};
    crosses = (s[15:8] != base[15:8]) || s[16];
  endfunction

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PTR  = 1'b1
  } seq_state_t;

  seq_state_t state;
  logic [15:0] next_pc;
  logic [15:0] stack_addr;
  logic        wide_m;
  logic        wide_any;
  logic        direct_mode;
  logic        page_mode;
  logic [3:0]  base_cycles;
  logic [3:0]  next_cycles;
  logic [2:0]  next_length;
  logic [3:0]  held_cycles;
  logic [2:0]  held_length;
  logic [23:0] base24;
  logic [24:0] eff_sum;
  logic        ptr_cross;

  assign wide_m   = ~i_acc_width_flag;
  assign wide_any = ~i_acc_width_flag | ~i_index_width_flag;

  assign stack_addr = stack_sum(i_stack_pointer, i_operand_low);

  assign direct_mode = (i_mode == addr_timing_pkg::MODE_DIR) || (i_mode == addr_timing_pkg::MODE_DIR_IDX_IND) ||
                       (i_mode == addr_timing_pkg::MODE_DIR_IND) || (i_mode == addr_timing_pkg::MODE_DIR_IND_IDX) ||
                       (i_mode == addr_timing_pkg::MODE_DIR_IND_LIDX) ||
                       (i_mode == addr_timing_pkg::MODE_DIR_IND_LONG) ||
                       (i_mode == addr_timing_pkg::MODE_DIR_X) || (i_mode == addr_timing_pkg::MODE_DIR_Y);
  assign page_mode = (i_mode == addr_timing_pkg::MODE_ABS_X) || (i_mode == addr_timing_pkg::MODE_ABS_Y) ||
                     (i_mode == addr_timing_pkg::MODE_DIR_IND_IDX);

  always_comb begin
    next_pc = i_program_counter;
    if (i_mode == addr_timing_pkg::MODE_REL && i_branch_taken) begin
      next_pc = i_program_counter + sext8(i_operand_low);
    end else if (i_mode == addr_timing_pkg::MODE_REL_LONG && i_branch_taken) begin
      next_pc = i_program_counter + {i_operand_high, i_operand_low};
    end
  end

  // base cycles and length
  always_comb begin
    base_cycles = addr_timing_pkg::CYC_TWO;
    next_length = addr_timing_pkg::LEN_TWO;
    case (i_mode)
      addr_timing_pkg::MODE_ABS, addr_timing_pkg::MODE_ABS_X, addr_timing_pkg::MODE_ABS_Y: begin
        base_cycles = addr_timing_pkg::CYC_ABS;
        next_length = addr_timing_pkg::LEN_THREE;
      end
      addr_timing_pkg::MODE_ABS_IDX_IND: begin
        base_cycles = addr_timing_pkg::CYC_ABS_IDX_IND;
        next_length = addr_timing_pkg::LEN_THREE;
      end
      addr_timing_pkg::MODE_ABS_IND: begin
        base_cycles = addr_timing_pkg::CYC_ABS_IND;
        next_length = addr_timing_pkg::LEN_THREE;
      end
      addr_timing_pkg::MODE_ABS_LONG, addr_timing_pkg::MODE_ABS_LONG_X: begin
        base_cycles = addr_timing_pkg::CYC_ABS_LONG;
        next_length = addr_timing_pkg::LEN_FOUR;
      end
      addr_timing_pkg::MODE_ACC, addr_timing_pkg::MODE_IMPLIED: begin
        base_cycles = addr_timing_pkg::CYC_TWO;
        next_length = addr_timing_pkg::LEN_ONE;
      end
      addr_timing_pkg::MODE_BLOCK_MOVE: begin
        base_cycles = addr_timing_pkg::CYC_BLOCK_MOVE;
        next_length = addr_timing_pkg::LEN_THREE;
      end
      addr_timing_pkg::MODE_DIR: begin
        base_cycles = addr_timing_pkg::CYC_DIR;
      end
      addr_timing_pkg::MODE_DIR_X, addr_timing_pkg::MODE_DIR_Y: begin
        base_cycles = addr_timing_pkg::CYC_DIR_X;
      end
      addr_timing_pkg::MODE_DIR_IND, addr_timing_pkg::MODE_DIR_IND_IDX: begin
        base_cycles = addr_timing_pkg::CYC_DIR_IND;
      end
      addr_timing_pkg::MODE_DIR_IDX_IND, addr_timing_pkg::MODE_DIR_IND_LIDX,
      addr_timing_pkg::MODE_DIR_IND_LONG: begin
        base_cycles = addr_timing_pkg::CYC_DIR_SIX;
      end
      addr_timing_pkg::MODE_IMM: begin
        base_cycles = addr_timing_pkg::CYC_TWO;
        next_length = addr_timing_pkg::LEN_TWO;
      end
      addr_timing_pkg::MODE_REL: begin
        base_cycles = addr_timing_pkg::CYC_REL;
      end
      addr_timing_pkg::MODE_REL_LONG: begin
        base_cycles = addr_timing_pkg::CYC_REL_LONG;
        next_length = addr_timing_pkg::LEN_THREE;
      end
      addr_timing_pkg::MODE_STACK: begin
        base_cycles = addr_timing_pkg::CYC_STACK;
        next_length = addr_timing_pkg::LEN_ONE;
      end
      addr_timing_pkg::MODE_STACK_REL: begin
        base_cycles = addr_timing_pkg::CYC_STACK_REL;
      end
      addr_timing_pkg::MODE_STACK_REL_IY: begin
        base_cycles = addr_timing_pkg::CYC_STACK_REL_IY;
      end
      default: begin
        base_cycles = addr_timing_pkg::CYC_TWO;
        next_length = addr_timing_pkg::LEN_TWO;
      end
    endcase
  end

  // adjustments to base cycles
  always_comb begin
    next_cycles = base_cycles;
    if ((i_mode == addr_timing_pkg::MODE_REL || i_mode == addr_timing_pkg::MODE_REL_LONG) && i_branch_taken) begin
      next_cycles = next_cycles + addr_timing_pkg::ADD_ONE;
    end
    if (page_mode && i_page_cross) begin
      next_cycles = next_cycles + addr_timing_pkg::ADD_ONE;
    end
    if (wide_any && (direct_mode || page_mode || i_mode == addr_timing_pkg::MODE_ABS ||
        i_mode == addr_timing_pkg::MODE_ABS_LONG || i_mode == addr_timing_pkg::MODE_ABS_LONG_X ||
        i_mode == addr_timing_pkg::MODE_IMM || i_mode == addr_timing_pkg::MODE_STACK_REL ||
        i_mode == addr_timing_pkg::MODE_STACK_REL_IY)) begin
      next_cycles = next_cycles + addr_timing_pkg::ADD_ONE;
    end
    if (direct_mode && (i_direct_base[7:0] != addr_timing_pkg::PAGE_ALIGN)) begin
      next_cycles = next_cycles + addr_timing_pkg::ADD_ONE;
    end
    if (i_rmw) begin
      next_cycles = next_cycles + (wide_m ? addr_timing_pkg::ADD_RMW_WIDE : addr_timing_pkg::ADD_RMW_NARROW);
    end
  end

  assign base24  = {i_data_bank_value, i_pointer_data};
  assign eff_sum = {1'b0, base24} + {9'h000, i_index_y};
  assign ptr_cross = crosses(i_pointer_data, i_index_y);

  // sequence state
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_IDLE;
    end else if (i_enable) begin
      case (state)
        ST_IDLE: begin
          if (i_start && i_mode == addr_timing_pkg::MODE_STACK_REL_IY) begin
            state <= ST_PTR;
          end
        end
        ST_PTR: begin
          // requests refused until pointer arrives
          if (i_pointer_valid) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // pointer request
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pointer_req     <= 1'b0;
      o_pointer_address <= 24'h000000;
    end else if (i_enable) begin
      if (state == ST_IDLE && i_start && i_mode == addr_timing_pkg::MODE_STACK_REL_IY) begin
        o_pointer_req     <= 1'b1;
        o_pointer_address <= {addr_timing_pkg::ZERO_BANK, stack_addr};
      end else if (state == ST_PTR && i_pointer_valid) begin
        o_pointer_req <= 1'b0;
      end
    end
  end

  // captured timing for the indirect case
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      held_cycles <= 4'h0;
      held_length <= 3'h0;
    end else if (i_enable && state == ST_IDLE && i_start) begin
      held_cycles <= next_cycles;
      held_length <= next_length;
    end
  end

  // results
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_valid             <= 1'b0;
      o_address           <= 24'h000000;
      o_next_pc           <= 16'h0000;
      o_next_program_bank <= 8'h00;
      o_cycles            <= 4'h0;
      o_length            <= 3'h0;
      o_page_crossed      <= 1'b0;
    end else if (i_enable) begin
      o_valid <= 1'b0;
      if (state == ST_PTR && i_pointer_valid) begin
        o_valid        <= 1'b1;
        o_address      <= eff_sum[23:0];
        o_cycles       <= held_cycles;
        o_length       <= held_length;
        o_page_crossed <= ptr_cross;
      end else if (state == ST_IDLE && i_start && i_mode != addr_timing_pkg::MODE_STACK_REL_IY) begin
        o_valid        <= 1'b1;
        o_cycles       <= next_cycles;
        o_page_crossed <= i_page_cross;
        o_next_pc      <= next_pc;
        o_next_program_bank <= i_program_bank_value;
        o_length <= next_length;
        if (i_mode == addr_timing_pkg::MODE_IMM && (i_imm_uses_index ? ~i_index_width_flag : wide_m)) begin
          o_length <= addr_timing_pkg::LEN_THREE;
        end
        if (i_mode == addr_timing_pkg::MODE_STACK_REL) begin
          o_address <= {addr_timing_pkg::ZERO_BANK, stack_addr};
        end else if (i_mode == addr_timing_pkg::MODE_STACK || i_vector_fetch) begin
          o_address <= {addr_timing_pkg::ZERO_BANK, i_stack_pointer};
          if (i_vector_fetch) begin
            o_address <= {addr_timing_pkg::ZERO_BANK, i_operand_high, i_operand_low};
          end
        end else begin
          o_address <= {i_program_bank_value, next_pc};
        end
      end
    end
  end

endmodule // stack_rel_addr_timing

/* stack_rel_addr_timing_assertions.sv */
// Purpose: concurrent checks on address, bank and cycle outputs
// Assumes: one clock, synchronous active-high reset
// Notes: requests refused while a pointer is awaited
`timescale 1ns/1ps
module stack_rel_addr_timing_checker (
  // clock and reset
  input wire logic                        i_clock,
  input wire logic                        i_rst,
  // request and core state
  input wire logic                        i_enable,
  input wire logic                        i_start,
  input wire addr_timing_pkg::addr_mode_t i_mode,
  input wire logic                        i_branch_taken,
  input wire logic                        i_rmw,
  input wire logic                        i_vector_fetch,
  input wire logic                        i_page_cross,
  input wire logic [7:0]                  i_operand_low,
  input wire logic [15:0]                 i_program_counter,
  input wire logic [7:0]                  i_program_bank_value,
  input wire logic [7:0]                  i_data_bank_value,
  input wire logic [15:0]                 i_stack_pointer,
  input wire logic [15:0]                 i_direct_base,
  input wire logic [15:0]                 i_index_y,
  input wire logic                        i_acc_width_flag,
  input wire logic                        i_index_width_flag,
  input wire logic                        i_pointer_valid,
  input wire logic [15:0]                 i_pointer_data,
  // results
  input wire logic                        o_valid,
  input wire logic [23:0]                 o_address,
  input wire logic [15:0]                 o_next_pc,
  input wire logic [7:0]                  o_next_program_bank,
  input wire logic                        o_pointer_req,
  input wire logic [23:0]                 o_pointer_address,
  input wire logic [3:0]                  o_cycles
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  wire logic take   = i_enable && i_start && !o_pointer_req;
  wire logic narrow = i_acc_width_flag && i_index_width_flag && !i_rmw;

  answer_time_a:
  assert property (take && i_mode != addr_timing_pkg::MODE_STACK_REL_IY |=> o_valid)
    else $error("result late");
  sr_address_a:
  assert property (take && i_mode == addr_timing_pkg::MODE_STACK_REL |=> o_address[23:16] == 8'h00
    && o_address[15:0] == $past(i_stack_pointer) + {8'h00, $past(i_operand_low)}) else $error("stack rel address");
  ptr_address_a:
  assert property (take && i_mode == addr_timing_pkg::MODE_STACK_REL_IY |=> o_pointer_req
    && o_pointer_address == {8'h00, 16'($past(i_stack_pointer) + {8'h00, $past(i_operand_low)})})
    else $error("pointer address");
  sriy_address_a:
  assert property (i_enable && o_pointer_req && i_pointer_valid |=> o_valid && !o_pointer_req
    && o_address == {$past(i_data_bank_value), $past(i_pointer_data)} + {8'h00, $past(i_index_y)})
    else $error("indirect indexed address");
  branch_pc_a:
  assert property (take && i_mode == addr_timing_pkg::MODE_REL && i_branch_taken
    |=> o_next_pc == $past(i_program_counter) + 16'($signed($past(i_operand_low)))) else $error("branch target");
  bank_kept_a:
  assert property (take && (i_mode == addr_timing_pkg::MODE_REL || i_mode == addr_timing_pkg::MODE_REL_LONG)
    |=> o_next_program_bank == $past(i_program_bank_value)) else $error("program bank changed");
  zero_bank_a:
  assert property (take && (i_mode == addr_timing_pkg::MODE_STACK || i_vector_fetch) |=> o_address[23:16] == 8'h00)
    else $error("stack bank not zero");
  rel_cycles_a:
  assert property (take && narrow && i_mode == addr_timing_pkg::MODE_REL
    |=> o_cycles == ($past(i_branch_taken) ? 4'h3 : 4'h2)) else $error("branch cycles");
  sr_cycles_a:
  assert property (take && narrow && i_mode == addr_timing_pkg::MODE_STACK_REL |=> o_cycles == 4'h4)
    else $error("stack rel cycles");
  page_cross_a:
  assert property (take && narrow && i_mode == addr_timing_pkg::MODE_ABS_X && i_page_cross |=> o_cycles == 4'h5)
    else $error("page cross cycles");
  dir_low_a:
  assert property (take && narrow && i_mode == addr_timing_pkg::MODE_DIR && i_direct_base[7:0] != 8'h00
    |=> o_cycles == 4'h4) else $error("direct low byte cycles");
  rmw_narrow_a:
  assert property (take && i_mode == addr_timing_pkg::MODE_ABS && i_rmw && i_acc_width_flag && i_index_width_flag
    |=> o_cycles == 4'h6) else $error("rmw cycles");

  cover property (take && i_mode == addr_timing_pkg::MODE_STACK_REL_IY);
  cover property (take && i_mode == addr_timing_pkg::MODE_REL && i_branch_taken);
  cover property (take && i_rmw);
endmodule // stack_rel_addr_timing_checker

bind stack_rel_addr_timing stack_rel_addr_timing_checker u_checker (
  .i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable), .i_start(i_start), .i_mode(i_mode),
  .i_branch_taken(i_branch_taken), .i_rmw(i_rmw), .i_vector_fetch(i_vector_fetch), .i_page_cross(i_page_cross),
  .i_operand_low(i_operand_low), .i_program_counter(i_program_counter), .i_program_bank_value(i_program_bank_value),
  .i_data_bank_value(i_data_bank_value), .i_stack_pointer(i_stack_pointer), .i_direct_base(i_direct_base),
  .i_index_y(i_index_y), .i_acc_width_flag(i_acc_width_flag), .i_index_width_flag(i_index_width_flag),
  .i_pointer_valid(i_pointer_valid), .i_pointer_data(i_pointer_data), .o_valid(o_valid), .o_address(o_address),
  .o_next_pc(o_next_pc), .o_next_program_bank(o_next_program_bank), .o_pointer_req(o_pointer_req),
  .o_pointer_address(o_pointer_address), .o_cycles(o_cycles)
);

/* test_stack_rel_addr_timing.sv */
// Purpose: directed scenarios for address forming and cycle accounting
// Assumes: pointer word answered one cycle after its request is seen
// Notes: width flags high mean 8-bit
`timescale 1ns/1ps
module test_stack_rel_addr_timing;
  logic                        i_clock, i_rst, i_enable, i_start, i_branch_taken, i_rmw, i_vector_fetch;
  logic                        i_imm_uses_index, i_page_cross, i_acc_width_flag, i_index_width_flag;
  logic                        i_pointer_valid, o_valid, o_pointer_req, o_page_crossed;
  addr_timing_pkg::addr_mode_t i_mode;
  logic [7:0]                  i_operand_low, i_operand_high, i_program_bank_value, i_data_bank_value;
  logic [7:0]                  o_next_program_bank;
  logic [15:0]                 i_program_counter, i_stack_pointer, i_direct_base, i_index_y, i_pointer_data;
  logic [15:0]                 o_next_pc;
  logic [23:0]                 o_address, o_pointer_address, ptr_addr;
  logic [3:0]                  o_cycles;
  logic [2:0]                  o_length;
  int                          error_cnt, checked;
  // mode code, base cycles, length
  logic [4:0]                  code [19] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0b,
                                             5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h16, 5'h13, 5'h14};
  logic [3:0]                  cyc [19] = '{4, 6, 5, 5, 5, 4, 4, 3, 6, 5, 5, 6, 6, 4, 4, 2, 4, 2, 3};
  logic [2:0]                  len [19] = '{3, 3, 3, 4, 4, 3, 3, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 3};

  stack_rel_addr_timing u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable), .i_start(i_start),
    .i_mode(i_mode), .i_branch_taken(i_branch_taken), .i_rmw(i_rmw), .i_vector_fetch(i_vector_fetch),
    .i_imm_uses_index(i_imm_uses_index), .i_page_cross(i_page_cross), .i_operand_low(i_operand_low),
    .i_operand_high(i_operand_high), .i_program_counter(i_program_counter), .i_program_bank_value(i_program_bank_value),
    .i_data_bank_value(i_data_bank_value), .i_stack_pointer(i_stack_pointer), .i_direct_base(i_direct_base),
    .i_index_y(i_index_y), .i_acc_width_flag(i_acc_width_flag), .i_index_width_flag(i_index_width_flag),
    .i_pointer_valid(i_pointer_valid), .i_pointer_data(i_pointer_data), .o_valid(o_valid), .o_address(o_address),
    .o_next_pc(o_next_pc), .o_next_program_bank(o_next_program_bank), .o_pointer_req(o_pointer_req),
    .o_pointer_address(o_pointer_address), .o_cycles(o_cycles), .o_length(o_length), .o_page_crossed(o_page_crossed));

  task automatic end_sim();
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic neutral(input logic [4:0] m);
    i_mode <= addr_timing_pkg::addr_mode_t'(m);
    i_branch_taken <= 1'b0;
    i_rmw <= 1'b0;
    i_vector_fetch <= 1'b0;
    i_imm_uses_index <= 1'b0;
    i_page_cross <= 1'b0;
    i_operand_low <= 8'h00;
    i_operand_high <= 8'h00;
    i_program_counter <= 16'h4000;
    i_program_bank_value <= 8'h5a;
    i_data_bank_value <= 8'h33;
    i_stack_pointer <= 16'h01f0;
    i_direct_base <= 16'h0000;
    i_index_y <= 16'h0000;
    i_acc_width_flag <= 1'b1;
    i_index_width_flag <= 1'b1;
    i_pointer_data <= 16'h0000;
  endtask

  // defaults, then an edge for overrides
  task automatic prep(input logic [4:0] m);
    @(posedge i_clock);
    neutral(m);
    @(posedge i_clock);
  endtask

  // pulse request, answer pointer, wait for result
  task automatic issue();
    int n;
    @(posedge i_clock);
    i_start <= 1'b1;
    @(posedge i_clock);
    i_start <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(negedge i_clock);
      if (o_valid === 1'b1) break;
      if (o_pointer_req === 1'b1) ptr_addr = o_pointer_address;
      @(posedge i_clock);
      i_pointer_valid <= (o_pointer_req === 1'b1) && (i_pointer_valid !== 1'b1);
    end
    check("o_valid", 24'h1, 24'(o_valid));
  endtask

  task automatic t_base_cycles();
    for (int i = 0; i < 19; i++) begin
      prep(code[i]);
      issue();
      check("base cycles", 24'(cyc[i]), 24'(o_cycles));
      check("length", 24'(len[i]), 24'(o_length));
    end
  endtask

  task automatic t_branch(input logic [4:0] m, input logic [15:0] pc, input logic [15:0] off, input logic [15:0] exp,
                          input logic [3:0] c);
    prep(m);
    i_branch_taken <= 1'b1;
    i_program_counter <= pc;
    {i_operand_high, i_operand_low} <= off;
    issue();
    check("branch pc", 24'(exp), 24'(o_next_pc));
    check("branch bank", 24'h00005a, 24'(o_next_program_bank));
    check("branch cycles", 24'(c), 24'(o_cycles));
  endtask

  task automatic t_stack();
    prep(addr_timing_pkg::MODE_STACK);
    i_data_bank_value <= 8'h77;
    issue();
    check("stack bank", 24'h0, 24'(o_address[23:16]));
    prep(addr_timing_pkg::MODE_STACK);
    i_vector_fetch <= 1'b1;
    {i_operand_high, i_operand_low} <= 16'hfffe;
    issue();
    check("vector address", 24'h00fffe, o_address);
  endtask

  task automatic t_stack_rel(input logic [15:0] sp, input logic [7:0] off, input logic [23:0] exp, input logic wide);
    prep(addr_timing_pkg::MODE_STACK_REL);
    i_stack_pointer <= sp;
    i_operand_low <= off;
    i_acc_width_flag <= !wide;
    issue();
    check("stack rel address", exp, o_address);
    check("stack rel cycles", 24'(4'h4 + 4'(wide)), 24'(o_cycles));
  endtask

  task automatic t_sriy();
    prep(addr_timing_pkg::MODE_STACK_REL_IY);
    i_operand_low <= 8'h10;
    i_data_bank_value <= 8'h12;
    i_pointer_data <= 16'h1234;
    i_index_y <= 16'h0010;
    issue();
    check("pointer address", 24'h000200, ptr_addr);
    check("indirect address", 24'h121244, o_address);
    check("indirect cycles", 24'h7, 24'(o_cycles));
    check("indirect length", 24'h2, 24'(o_length));
  endtask

  task automatic t_adjust(input logic [4:0] m, input logic pg, input logic [15:0] db, input logic rmw,
                          input logic acc, input logic idx, input logic immx, input logic [3:0] c, input logic [2:0] l);
    prep(m);
    i_page_cross <= pg;
    i_direct_base <= db;
    i_rmw <= rmw;
    i_acc_width_flag <= acc;
    i_index_width_flag <= idx;
    i_imm_uses_index <= immx;
    issue();
    check("adjusted cycles", 24'(c), 24'(o_cycles));
    check("adjusted length", 24'(l), 24'(o_length));
    check("page crossed", 24'(pg), 24'(o_page_crossed));
  endtask

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  initial begin
    repeat (5000) @(posedge i_clock);
    error_cnt++;
    end_sim();
  end

  initial begin
    i_rst <= 1'b1;
    i_enable <= 1'b1;
    i_start <= 1'b0;
    i_pointer_valid <= 1'b0;
    neutral(5'h00);
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    t_base_cycles();
    t_branch(5'h13, 16'hfff0, 16'h0020, 16'h0010, 4'h3);
    t_branch(5'h13, 16'h1000, 16'h0080, 16'h0f80, 4'h3);
    t_branch(5'h13, 16'h1000, 16'h007f, 16'h107f, 4'h3);
    t_branch(5'h14, 16'h8000, 16'h9000, 16'h1000, 4'h4);
    t_stack();
    t_stack_rel(16'h01ff, 8'hff, 24'h0002fe, 1'b0);
    t_stack_rel(16'hffff, 8'hff, 24'h0000fe, 1'b0);
    t_stack_rel(16'h1000, 8'h80, 24'h001080, 1'b1);
    t_sriy();
    t_adjust(5'h05, 1'b1, 16'h0000, 1'b0, 1'b1, 1'b1, 1'b0, 4'h5, 3'h3);
    t_adjust(5'h09, 1'b0, 16'h0012, 1'b0, 1'b1, 1'b1, 1'b0, 4'h4, 3'h2);
    t_adjust(5'h09, 1'b0, 16'h1200, 1'b0, 1'b1, 1'b1, 1'b0, 4'h3, 3'h2);
    t_adjust(5'h11, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b0, 4'h3, 3'h3);
    t_adjust(5'h11, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 4'h3, 3'h3);
    t_adjust(5'h11, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b0, 4'h3, 3'h2);
    t_adjust(5'h00, 1'b0, 16'h0000, 1'b1, 1'b1, 1'b1, 1'b0, 4'h6, 3'h3);
    t_adjust(5'h00, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b1, 1'b0, 4'h8, 3'h3);
    end_sim();
  end
endmodule // test_stack_rel_addr_timing
